// file: logic/tcp_map.svh
// Register map, field positions and counter and divider constants of the timer channel.
// Assumes a 32-bit AHB-Lite slave decoding byte address bits [7:0].
// Functional notes
// - Capture edge on pin sets channel flag
// - Counter equals channel value sets flag
// - No flag at 0% or 100% PWM
// - Interrupt when flag and enable both set
// - Flag cleared by read then write zero
// - New event restarts clear sequence, flag stays
// - Writing one ignored; reset clears flag, enable
// - Enable bit six: zero polls, one interrupts
// - Mode B without center select: edge PWM
// - Center select gives up/down counting PWM
// - Count up to modulus, down to zero
// - Period twice modulus, pulse twice value
// - Zero or negative value gives 0% duty
// - Value above nonzero modulus gives 100% duty
// - Select A zero: up match low, down high
// - Zero modulus: free run 0x0000 to 0xFFFF; with center select the count turns down at 0x0000 instead
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

`define TCP_A_CSC      8'h00
`define TCP_A_CTRL     8'h04
`define TCP_A_MOD      8'h08
`define TCP_A_CHVAL    8'h0C
`define TCP_A_CNT      8'h10
`define TCP_A_IRQ_ST   8'h14
`define TCP_A_IRQ_CLR  8'h18
`define TCP_A_IRQ_EN   8'h1C

`define TCP_CSC_FLAG   7
`define TCP_CSC_IE     6
`define TCP_CSC_MSB    5
`define TCP_CSC_MSA    4
`define TCP_CSC_ELSB   3
`define TCP_CSC_ELSA   2
`define TCP_CTRL_CENTER_ALIGN_SELECT 0
`define TCP_CTRL_CLR   1
`define TCP_IRQ_CH     0
`define TCP_IRQ_TOF    1

`define TCP_CNT_MAX    16'hFFFF
`define TCP_DIV_DEF    8

`endif

// file: logic/tcp_pkg.sv
// Types shared by the timer channel and its bus carrier.
// Assumes tcp_map.svh for all numeric constants.
`default_nettype none
package tcp_pkg;
	typedef enum logic [1:0] {
		TCP_CAPTURE = 2'b00,
		TCP_COMPARE = 2'b01,
		TCP_EPWM    = 2'b10,
		TCP_CENTER_PWM_OUTPUT    = 2'b11
	} tcp_mode_t;

	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} tcp_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} tcp_ahb_rsp_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic        down;
		logic [7:0]  div;
		logic        flag;
		logic        armed;
		logic        ie;
		logic        msb;
		logic        msa;
		logic        elsb;
		logic        elsa;
		logic        center_align_select;
		logic [15:0] modv;
		logic [15:0] chval;
		logic        level;
		logic        pin_prev;
		logic [1:0]  irq_st;
		logic [1:0]  irq_en;
		logic        wr;
		logic [7:0]  waddr;
		tcp_ahb_rsp_t rsp;
		logic        pin_out;
		logic        pin_oe;
		logic        irq;
	} tcp_state_t;
endpackage : tcp_pkg
`default_nettype wire

// file: logic/tcp_channel.sv
// One timer channel: counter, capture/compare, edge and center PWM, AHB-Lite regs.
// Assumes a single synchronous clock; pin input already synchronous to it.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`include "tcp_map.svh"
`default_nettype none
module tcp_channel
	import tcp_pkg::*;
#(
	parameter int unsigned DIV = `TCP_DIV_DEF
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Register bus
	input  wire tcp_ahb_req_t ahb_req,
	output var  tcp_ahb_rsp_t ahb_rsp,
	// Channel pin
	input  wire logic         ch_pin_in,
	output var  logic         ch_pin_out,
	output var  logic         ch_pin_oe,
	// Interrupt
	output var  logic         irq
);

	tcp_state_t r;
	tcp_state_t n;

	logic      tick;
	logic      match;
	logic      wrap;
	logic      zero_duty;
	logic      full_duty;
	logic      pwm;
	logic      cap_ev;
	logic      ch_ev;
	logic      addr_ph;
	tcp_mode_t md;

	function automatic tcp_mode_t mode_of(input logic center_align_select, input logic msb,
			input logic msa);
		if (center_align_select) begin
			mode_of = TCP_CENTER_PWM_OUTPUT;
		end else if (msb) begin
			mode_of = TCP_EPWM;
		end else if (msa) begin
			mode_of = TCP_COMPARE;
		end else begin
			mode_of = TCP_CAPTURE;
		end
	endfunction : mode_of

	function automatic logic [31:0] rd_word(input tcp_state_t s, input logic [7:0] a);
		rd_word = 32'h0000_0000;
		case (a)
			`TCP_A_CSC:     rd_word[7:0] = {s.flag, s.ie, s.msb, s.msa, s.elsb, s.elsa, 2'b00};
			`TCP_A_CTRL:    rd_word[`TCP_CTRL_CENTER_ALIGN_SELECT] = s.center_align_select;
			`TCP_A_MOD:     rd_word[15:0] = s.modv;
			`TCP_A_CHVAL:   rd_word[15:0] = s.chval;
			`TCP_A_CNT:     rd_word[15:0] = s.cnt;
			`TCP_A_IRQ_ST:  rd_word[1:0] = s.irq_st;
			`TCP_A_IRQ_EN:  rd_word[1:0] = s.irq_en;
			default:        rd_word = 32'h0000_0000;
		endcase
	endfunction : rd_word

	always_comb begin
		n = r;
		n.rsp.hreadyout = 1'b1;
		n.rsp.hresp = 1'b0;
		md = mode_of(r.center_align_select, r.msb, r.msa);
		pwm = (md == TCP_EPWM) || (md == TCP_CENTER_PWM_OUTPUT);
		tick = (r.div == 8'(DIV - 1));
		n.div = tick ? 8'h00 : r.div + 8'h01;
		match = tick && (r.cnt == r.chval);
		zero_duty = (r.chval == 16'h0000) || r.chval[15];
		full_duty = !r.chval[15] && (r.chval > r.modv) && (r.modv != 16'h0000);
		wrap = 1'b0;

		// Counter
		if (tick) begin
			if (r.center_align_select) begin
				if (!r.down && r.cnt == r.modv) begin
					n.down = 1'b1;
					n.cnt = r.cnt - 16'h0001;
				end else if (r.down && r.cnt == 16'h0000) begin
					n.down = 1'b0;
					n.cnt = 16'h0001;
					wrap = 1'b1;
				end else begin
					n.cnt = r.down ? r.cnt - 16'h0001 : r.cnt + 16'h0001;
				end
			end else begin
				n.down = 1'b0;
				// Zero modulus falls through to the natural 16-bit rollover
				if (r.modv != 16'h0000 && r.cnt == r.modv) begin
					n.cnt = 16'h0000;
					wrap = 1'b1;
				end else begin
					n.cnt = r.cnt + 16'h0001;
					wrap = (r.cnt == `TCP_CNT_MAX);
				end
			end
		end

		// Channel events
		n.pin_prev = ch_pin_in;
		cap_ev = (md == TCP_CAPTURE) && ((r.elsa && ch_pin_in && !r.pin_prev)
			|| (r.elsb && !ch_pin_in && r.pin_prev));
		ch_ev = cap_ev || ((md != TCP_CAPTURE) && match
			&& !(pwm && (zero_duty || full_duty)));
		if (cap_ev) begin
			n.chval = r.cnt;
		end

		// Output level
		case (md)
			TCP_CENTER_PWM_OUTPUT: begin
				if (zero_duty) begin
					n.level = 1'b0;
				end else if (full_duty) begin
					n.level = 1'b1;
				end else if (match) begin
					n.level = r.down;
				end
			end
			TCP_EPWM: begin
				if (zero_duty) begin
					n.level = 1'b0;
				end else if (full_duty || (wrap && !match)) begin
					n.level = 1'b1;
				end else if (match) begin
					n.level = 1'b0;
				end
			end
			TCP_COMPARE: begin
				if (match) begin
					n.level = !r.level;
				end
			end
			default: n.level = 1'b0;
		endcase

		// Bus address phase
		addr_ph = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
		if (addr_ph) begin
			n.wr = ahb_req.hwrite;
			n.waddr = ahb_req.haddr;
			n.rsp.hrdata = ahb_req.hwrite ? 32'h0000_0000 : rd_word(r, ahb_req.haddr);
			if (!ahb_req.hwrite && ahb_req.haddr == `TCP_A_CSC && r.flag) begin
				n.armed = 1'b1;
			end
		end else if (ahb_req.hready) begin
			n.wr = 1'b0;
		end

		// Bus data phase
		if (r.wr) begin
			case (r.waddr)
				`TCP_A_CSC: begin
					n.ie = ahb_req.hwdata[`TCP_CSC_IE];
					n.msb = ahb_req.hwdata[`TCP_CSC_MSB];
					n.msa = ahb_req.hwdata[`TCP_CSC_MSA];
					n.elsb = ahb_req.hwdata[`TCP_CSC_ELSB];
					n.elsa = ahb_req.hwdata[`TCP_CSC_ELSA];
					// A one written to the flag bit is ignored
					if (!ahb_req.hwdata[`TCP_CSC_FLAG] && r.armed) begin
						n.flag = 1'b0;
					end
					n.armed = 1'b0;
				end
				`TCP_A_CTRL: begin
					n.center_align_select = ahb_req.hwdata[`TCP_CTRL_CENTER_ALIGN_SELECT];
					if (ahb_req.hwdata[`TCP_CTRL_CLR]) begin
						n.cnt = 16'h0000;
						n.down = 1'b0;
						n.div = 8'h00;
					end
				end
				`TCP_A_MOD:     n.modv = ahb_req.hwdata[15:0];
				`TCP_A_CHVAL:   n.chval = ahb_req.hwdata[15:0];
				`TCP_A_IRQ_CLR: n.irq_st = r.irq_st & ~ahb_req.hwdata[1:0];
				`TCP_A_IRQ_EN:  n.irq_en = ahb_req.hwdata[1:0];
				default: begin
				end
			endcase
		end

		// Hardware sets win over software clears
		if (ch_ev) begin
			n.flag = 1'b1;
			n.armed = 1'b0;
			n.irq_st[`TCP_IRQ_CH] = 1'b1;
		end
		if (wrap) begin
			n.irq_st[`TCP_IRQ_TOF] = 1'b1;
		end

		n.pin_out = n.level ^ n.elsa;
		n.pin_oe = (mode_of(n.center_align_select, n.msb, n.msa) != TCP_CAPTURE) && (n.elsa || n.elsb);
		n.irq = (n.flag && n.ie) || |(n.irq_st & n.irq_en);
	end

	// Reset clears flag and enable along with everything else
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ahb_rsp = r.rsp;
	assign ch_pin_out = r.pin_out;
	assign ch_pin_oe = r.pin_oe;
	assign irq = r.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	flag_on_event_a: assert property (ch_ev |=> r.flag)
		else $error("channel event did not set flag");
	no_flag_pwm_a: assert property (!r.flag && pwm && (zero_duty || full_duty)
		&& !cap_ev |=> !r.flag)
		else $error("flag set at 0 or 100 percent duty");
	irq_follows_a: assert property (r.flag && r.ie && !r.wr |=> r.irq)
		else $error("enabled flag gave no interrupt");
	clear_needs_arm_a: assert property (r.flag && !r.armed |=> r.flag)
		else $error("flag cleared without read first");
	restart_seq_a: assert property (ch_ev |=> r.flag && !r.armed)
		else $error("new event did not restart clearing");
	write_one_a: assert property (r.wr && r.waddr == `TCP_A_CSC && !r.flag && !ch_ev
		|=> !r.flag)
		else $error("write set the flag");
	ie_write_a: assert property (r.wr && r.waddr == `TCP_A_CSC
		|=> r.ie == $past(ahb_req.hwdata[`TCP_CSC_IE]))
		else $error("interrupt enable not written");
	epwm_mode_a: assert property (!r.center_align_select && r.msb |-> md == TCP_EPWM)
		else $error("mode B did not select edge PWM");
	turnaround_a: assert property (tick && r.center_align_select && !r.down && r.cnt == r.modv
		&& r.modv != 16'h0000 && !r.wr
		|=> r.down && r.cnt == $past(r.cnt) - 16'h0001)
		else $error("counter did not turn at modulus");
	bottom_turn_a: assert property (tick && r.center_align_select && r.down && r.cnt == 16'h0000
		&& !r.wr |=> !r.down && r.cnt == 16'h0001)
		else $error("counter did not turn at zero");
	zero_duty_a: assert property (md == TCP_CENTER_PWM_OUTPUT && zero_duty && !r.wr
		|=> !r.level ##1 r.pin_out == r.elsa)
		else $error("zero value did not give 0 percent");
	full_duty_a: assert property (md == TCP_CENTER_PWM_OUTPUT && full_duty && !zero_duty && !r.wr
		|=> r.level)
		else $error("large value did not give 100 percent");
	up_match_a: assert property (md == TCP_CENTER_PWM_OUTPUT && match && !r.down && !zero_duty
		&& !full_duty && !r.wr |=> !r.level)
		else $error("up match did not drive low");
	polarity_a: assert property (md == TCP_CENTER_PWM_OUTPUT && !r.wr |=> r.pin_out == (r.level ^ r.elsa))
		else $error("output polarity wrong");
	free_run_a: assert property (tick && !r.center_align_select && r.modv == 16'h0000
		&& r.cnt == `TCP_CNT_MAX && !r.wr |=> r.cnt == 16'h0000)
		else $error("counter did not roll over");

	center_pwm_output_event_c: cover property (ch_ev && md == TCP_CENTER_PWM_OUTPUT);
	clear_done_c: cover property (r.armed ##1 !r.flag);
	irq_raise_c: cover property (!r.irq ##1 r.irq);
	capture_c: cover property (cap_ev);

endmodule : tcp_channel
`default_nettype wire

// file: testbench/tcp_pin_model.sv
// Far side of the channel pin: a signal source that yields to the channel.
// Assumes the channel output enable is high while the channel drives the pin.
`default_nettype none
module tcp_pin_model (
	// Level commanded by the bench
	input  wire logic lvl,
	// Channel side of the wire
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output var  logic pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Channel wins the wire while enabled, so no contention is modelled
	always_comb pin_in = pin_oe ? pin_out : lvl;
endmodule : tcp_pin_model
`default_nettype wire

// file: testbench/timer_channel_center_pwm_test.sv
// Bench for the timer channel: AHB-Lite register tasks, capture and PWM runs.
// Assumes DIV of 1, so the counter ticks on every clock.
`include "tcp_map.svh"
`default_nettype none
module timer_channel_center_pwm_test
	import tcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MODV = 16'h0004;
	logic         core_clk;
	logic         rst;
	logic         lvl;
	logic         pin_in, pin_out, pin_oe, irq;
	tcp_ahb_req_t m, req;
	tcp_ahb_rsp_t rsp;
	int           err_total, samples_checked;
	logic [31:0]  rd;
	int           hi;
	logic [15:0]  cvs [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h8000, 16'h0005, 16'h0000};
	logic         els [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

	always_comb begin
		req = m;
		req.hready = rsp.hreadyout;
	end

	tcp_channel #(.DIV(1)) tcp_channel_inst (.core_clk(core_clk), .rst(rst),
		.ahb_req(req), .ahb_rsp(rsp), .ch_pin_in(pin_in), .ch_pin_out(pin_out),
		.ch_pin_oe(pin_oe), .irq(irq));
	tcp_pin_model tcp_pin_model_inst (.lvl(lvl), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in(pin_in));

	task automatic results();
		$display("checked %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// Samples before this edge's updates land, as a bus master does
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge core_clk);
		while (rsp.hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				err_total++;
				results();
			end
			@(posedge core_clk);
		end
	endtask : wait_rdy

	// Leading idle cycle keeps a read clear of the previous write
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		m.hsel <= 1'b1;
		m.haddr <= a;
		m.htrans <= 2'b10;
		m.hwrite <= w;
		wait_rdy();
		m.hsel <= 1'b0;
		m.htrans <= 2'b00;
		m.hwdata <= d;
		wait_rdy();
		rd = rsp.hrdata;
		chk("hresp", rsp.hresp, 32'h0000_0000);
	endtask : bus

	task automatic irq_is(input logic e);
		repeat (2) @(negedge core_clk);
		chk("irq", irq, e);
	endtask : irq_is

	// Pulse width counted over one full period, so phase does not matter
	task automatic pwm(input logic [15:0] cv, input logic el);
		int h, e;
		logic [31:0] cfg;
		cfg = 32'h0000_0008 | (el << 2);
		bus(1'b1, `TCP_A_CHVAL, {16'h0000, cv});
		bus(1'b1, `TCP_A_CSC, cfg);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		bus(1'b1, `TCP_A_CSC, cfg);
		repeat (16) @(negedge core_clk);
		chk("pin enable", pin_oe, 1'b1);
		h = 0;
		repeat (2 * MODV) begin
			@(negedge core_clk);
			if (pin_out === 1'b1) h++;
		end
		e = (cv == 0 || cv[15]) ? 0 : (cv > MODV) ? 2 * MODV : 2 * cv;
		if (el) e = 2 * MODV - e;
		chk("pulse width", h, e);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("pwm flag", rd[7], e != 0 && e != 2 * MODV);
	endtask : pwm

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		rst = 1'b1;
		lvl = 1'b0;
		m = '0;
		m.hsize = 3'b010;
		err_total = 0;
		samples_checked = 0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("csc reset", rd, 32'h0000_0000);
		bus(1'b0, `TCP_A_IRQ_EN, 32'h0000_0000);
		chk("irq enable reset", rd, 32'h0000_0000);
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		// Capture on both edges, channel interrupt off
		bus(1'b1, `TCP_A_CSC, 32'h0000_000C);
		lvl <= 1'b1;
		irq_is(1'b0);
		bus(1'b0, `TCP_A_IRQ_ST, 32'h0000_0000);
		chk("status", rd & 32'h0000_0001, 32'h0000_0001);
		bus(1'b1, `TCP_A_IRQ_EN, 32'h0000_0001);
		irq_is(1'b1);
		bus(1'b1, `TCP_A_IRQ_CLR, 32'h0000_0001);
		irq_is(1'b0);
		bus(1'b1, `TCP_A_CSC, 32'h0000_004C);
		irq_is(1'b1);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("csc flag", rd, 32'h0000_00CC);
		bus(1'b1, `TCP_A_CSC, 32'h0000_00CC);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("write one", rd, 32'h0000_00CC);
		lvl <= 1'b0;
		repeat (2) @(negedge core_clk);
		bus(1'b1, `TCP_A_CSC, 32'h0000_004C);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("restart", rd, 32'h0000_00CC);
		bus(1'b1, `TCP_A_CSC, 32'h0000_004C);
		bus(1'b0, `TCP_A_CSC, 32'h0000_0000);
		chk("cleared", rd, 32'h0000_004C);
		bus(1'b1, `TCP_A_IRQ_CLR, 32'h0000_0001);
		irq_is(1'b0);
		// Center PWM with the counter reset ahead of the modulus
		bus(1'b1, `TCP_A_CTRL, 32'h0000_0002);
		bus(1'b1, `TCP_A_MOD, {16'h0000, MODV});
		bus(1'b1, `TCP_A_CTRL, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			pwm(cvs[i], els[i]);
		end
		// Edge PWM: high from wrap until the match, period of modulus plus one
		bus(1'b1, `TCP_A_CTRL, 32'h0000_0000);
		bus(1'b1, `TCP_A_CHVAL, 32'h0000_0002);
		bus(1'b1, `TCP_A_CSC, 32'h0000_0028);
		repeat (16) @(negedge core_clk);
		hi = 0;
		repeat (MODV + 1) begin
			@(negedge core_clk);
			if (pin_out === 1'b1) hi++;
		end
		chk("edge pwm width", hi, 32'h0000_0003);
		results();
	end
endmodule : timer_channel_center_pwm_test
`default_nettype wire
